// [qtipp_pkg.sv]
`default_nettype none
package qtipp_pkg;
  // Three-level static selects are carried as two-bit codes.
  localparam logic [1:0] TRIT_LOW  = 2'h0;
  localparam logic [1:0] TRIT_MID  = 2'h1;
  localparam logic [1:0] TRIT_HIGH = 2'h2;
  // Layout of one captured word: special_char_select, parity, control, character.
  localparam int CHAR_W = 8;
  localparam int CTRL_W = 2;
  localparam int WD_LSB = 0;
  localparam int WC_LSB = 8;
  localparam int WP_BIT = 10;
  localparam int WS_BIT = 11;
  localparam int WORD_W = 12;
  localparam int CODE_W = 10;
  // Positive-disparity violation character sent in encoder bypass.
  localparam logic [9:0] C07_POS = 10'h278;
  // Control pair that asks for a word sync sequence.
  localparam logic [1:0] CTL_WSYNC = 2'h3;
  localparam int WS_LEN = 16;
  // Channel count and phase-align buffer depth.
  localparam int NCH_DEF   = 4;
  localparam int BUF_DEPTH = 16;
  // Character period against the reference clock.
  localparam int MCLK_NS  = 40;
  localparam int CHAR_NS  = 320;
  localparam int CHAR_DIV = CHAR_NS / MCLK_NS;
  // Reference edges that must see the buffer reset low.
  localparam int RST_LOW_EDGES = 2;
  // Source handed to the encoder with each character.
  typedef enum logic [2:0] {
    SRC_RAW,
    SRC_DATA,
    SRC_SPECIAL,
    SRC_VIOL,
    SRC_BIST,
    SRC_K285,
    SRC_WSYNC
  } qtipp_src_t;
  // Odd parity over the bits that the parity control selects.
  function automatic logic qtipp_parity_ok(input logic [7:0] d,
                                           input logic [1:0] c,
                                           input logic       p,
                                           input logic [1:0] pctl,
                                           input logic       enc_en);
    logic sum;
    sum = 1'b1;
    if (pctl == TRIT_MID && enc_en)
      sum = ^{d, p};
    else if (pctl != TRIT_LOW)
      sum = ^{d, c, p};
    return sum;
  endfunction : qtipp_parity_ok
endpackage : qtipp_pkg
`default_nettype wire

// [qtipp_tx_front.sv]
`timescale 1ns/1ps
`default_nettype none

module qtipp_fifo #(
  parameter int WIDTH = qtipp_pkg::WORD_W,
  parameter int DEPTH = qtipp_pkg::BUF_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             flush,
  // Fill side.
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side.
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  output logic [AW:0]           level
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } qtipp_fifo_st_t;

  qtipp_fifo_st_t st;
  qtipp_fifo_st_t nx;
  logic           wr;
  logic           rd;

  // Pointer step that also suits depths that are not powers of two.
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  // Ready and valid come from the count, so full and empty are exact.
  assign in_ready  = (st.count != (AW + 1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rptr];
  assign level     = st.count;
  assign wr        = in_valid && in_ready;
  assign rd        = out_ready && out_valid;

  // Next state; a flush empties the buffer and drops both sides.
  always_comb
  begin
    nx = st;
    if (flush)
    begin
      nx.wptr  = '0;
      nx.rptr  = '0;
      nx.count = '0;
    end
    else
    begin
      if (wr)
      begin
        nx.mem[st.wptr] = in_data;
        nx.wptr         = step(st.wptr);
      end
      if (rd)
        nx.rptr = step(st.rptr);
      if (wr && !rd)
        nx.count = st.count + 1'b1;
      else if (rd && !wr)
        nx.count = st.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= nx;
  end
endmodule : qtipp_fifo

module qtipp_tx_front #(
  parameter int NCH      = qtipp_pkg::NCH_DEF,
  parameter int DEPTH    = qtipp_pkg::BUF_DEPTH,
  parameter int CHAR_DIV = qtipp_pkg::CHAR_DIV
) (
  // Reference clock and reset.
  input  wire logic              mclk,
  input  wire logic              resetn,
  // Host character bus, one lane per channel.
  input  wire logic [NCH-1:0]    chan_input_clock,
  input  wire logic [NCH*8-1:0]  tx_char_bits,
  input  wire logic [NCH*2-1:0]  tx_ctrl_bits,
  input  wire logic [NCH-1:0]    tx_parity_bit,
  input  wire logic              special_char_select,
  // Static configuration and buffer reset.
  input  wire logic [3:0]        tx_mode_select,
  input  wire logic [1:0]        tx_clock_select,
  input  wire logic              tx_rate_select,
  input  wire logic [1:0]        parity_control,
  input  wire logic              tx_buffer_reset,
  // Encoder side.
  output logic                   enc_strobe,
  output logic [NCH*10-1:0]      enc_char,
  output logic [NCH*3-1:0]       enc_source,
  output logic                   enc_special,
  output logic [NCH-1:0]         tx_error_flag
);
  localparam int DW = $clog2(CHAR_DIV + 1);
  localparam int LW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [NCH-1:0]                     ck_s1;
    logic [NCH-1:0]                     ck_s2;
    logic [NCH-1:0]                     ck_s3;
    logic [NCH*8-1:0]                   d_s1;
    logic [NCH*8-1:0]                   d_s2;
    logic [NCH*2-1:0]                   c_s1;
    logic [NCH*2-1:0]                   c_s2;
    logic [NCH-1:0]                     p_s1;
    logic [NCH-1:0]                     p_s2;
    logic                               sc_s1;
    logic                               sc_s2;
    logic [3:0]                         m_s1;
    logic [3:0]                         m_s2;
    logic [1:0]                         ck_sel_s1;
    logic [1:0]                         ck_sel_s2;
    logic                               rate_s1;
    logic                               rate_s2;
    logic [1:0]                         pc_s1;
    logic [1:0]                         pc_s2;
    logic                               rst_s1;
    logic                               rst_s2;
    logic [1:0]                         rst_lo;
    logic [DW-1:0]                      div;
    logic                               stb;
    logic [NCH-1:0]                     run;
    logic [NCH-1:0]                     err;
    logic [NCH-1:0]                     perr;
    logic [NCH-1:0]                     flag;
    logic [NCH-1:0][3:0]                ws;
    logic [NCH-1:0][9:0]                chr;
    logic [NCH-1:0][2:0]                src;
    logic                               out_stb;
    logic                               special;
  } qtipp_top_st_t;

  qtipp_top_st_t                            st;
  qtipp_top_st_t                            nx;
  logic                                     hold;
  logic                                     enc_en;
  logic                                     atomic;
  logic                                     buf_en;
  logic                                     sc_in;
  logic                                     sc_app;
  logic [NCH-1:0]                           edge_sel;
  logic [NCH-1:0]                           fifo_wr;
  logic [NCH-1:0]                           fifo_wready;
  logic [NCH-1:0]                           fifo_rd;
  logic [NCH-1:0]                           fifo_rvalid;
  logic [NCH-1:0]                           fifo_flush;
  logic [NCH-1:0]                           recenter;
  logic [NCH-1:0]                           vld;
  logic [NCH-1:0]                           perr;
  logic [NCH-1:0]                           ws_req;
  logic [NCH-1:0][qtipp_pkg::WORD_W-1:0]    wdata;
  logic [NCH-1:0][qtipp_pkg::WORD_W-1:0]    rdata;
  logic [NCH-1:0][qtipp_pkg::WORD_W-1:0]    word;
  logic [NCH-1:0][LW-1:0]                   level;

  // Mode decode from the synchronised static selects.
  // encoder enable
  assign enc_en = (st.m_s2[3:2] != qtipp_pkg::TRIT_LOW);
  assign atomic = (st.m_s2[3:2] == qtipp_pkg::TRIT_MID);
  assign buf_en = (st.ck_sel_s2 != qtipp_pkg::TRIT_LOW) || st.rate_s2;
  // second low edge holds the buffers
  assign hold = !st.rst_s2 && (st.rst_lo == 2'(qtipp_pkg::RST_LOW_EDGES - 1));
  // special select kept only when lower mode is not high
  assign sc_in = st.sc_s2 && (st.m_s2[1:0] != qtipp_pkg::TRIT_HIGH);
  // channel A's captured select drives every channel
  assign sc_app = word[0][qtipp_pkg::WS_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      // Capture strobe: the internal character strobe when the clock select is low, else the selected input clock's rising edge.
      assign edge_sel[gi] =
        (st.ck_sel_s2 == qtipp_pkg::TRIT_LOW) ? st.stb :
        (st.ck_sel_s2 == qtipp_pkg::TRIT_MID) ? (st.ck_s2[gi] && !st.ck_s3[gi]) :
                                                (st.ck_s2[0] && !st.ck_s3[0]);
      assign wdata[gi] = {sc_in, st.p_s2[gi], st.c_s2[2*gi +: 2], st.d_s2[8*gi +: 8]};
      assign fifo_wr[gi] = buf_en && edge_sel[gi] && !hold;
      assign fifo_rd[gi] = buf_en && st.stb && st.run[gi] && !hold;
      assign word[gi] = buf_en ? rdata[gi] : wdata[gi];
      assign vld[gi] = buf_en ? (fifo_rd[gi] && fifo_rvalid[gi]) : st.stb;
      assign perr[gi] = vld[gi] && !qtipp_pkg::qtipp_parity_ok(
                          word[gi][qtipp_pkg::WD_LSB +: qtipp_pkg::CHAR_W],
                          word[gi][qtipp_pkg::WC_LSB +: qtipp_pkg::CTRL_W],
                          word[gi][qtipp_pkg::WP_BIT], st.pc_s2, enc_en);
      assign ws_req[gi] = (word[gi][qtipp_pkg::WC_LSB +: 2] == qtipp_pkg::CTL_WSYNC);
      // word sync read during an atomic-mode error recentres
      assign recenter[gi] = atomic && st.err[gi] && vld[gi] && buf_en && ws_req[gi];
      assign fifo_flush[gi] = hold || recenter[gi];

      qtipp_fifo #(
        .WIDTH (qtipp_pkg::WORD_W),
        .DEPTH (DEPTH)
      ) u_align (
        .mclk      (mclk),
        .resetn    (resetn),
        .flush     (fifo_flush[gi]),
        .in_valid  (fifo_wr[gi]),
        .in_data   (wdata[gi]),
        .in_ready  (fifo_wready[gi]),
        .out_ready (fifo_rd[gi]),
        .out_valid (fifo_rvalid[gi]),
        .out_data  (rdata[gi]),
        .level     (level[gi])
      );
    end
  endgenerate

  // Next state. Every pin passes two flops before logic reads it.
  always_comb
  begin
    nx           = st;
    nx.ck_s1     = chan_input_clock;
    nx.ck_s2     = st.ck_s1;
    nx.ck_s3     = st.ck_s2;
    nx.d_s1      = tx_char_bits;
    nx.d_s2      = st.d_s1;
    nx.c_s1      = tx_ctrl_bits;
    nx.c_s2      = st.c_s1;
    nx.p_s1      = tx_parity_bit;
    nx.p_s2      = st.p_s1;
    nx.sc_s1     = special_char_select;
    nx.sc_s2     = st.sc_s1;
    nx.m_s1      = tx_mode_select;
    nx.m_s2      = st.m_s1;
    nx.ck_sel_s1 = tx_clock_select;
    nx.ck_sel_s2 = st.ck_sel_s1;
    nx.rate_s1   = tx_rate_select;
    nx.rate_s2   = st.rate_s1;
    nx.pc_s1     = parity_control;
    nx.pc_s2     = st.pc_s1;
    nx.rst_s1    = tx_buffer_reset;
    nx.rst_s2    = st.rst_s1;
    // Internal character clock divided down from the reference.
    nx.stb = (st.div == DW'(CHAR_DIV - 1));
    nx.div = nx.stb ? '0 : st.div + 1'b1;
    nx.out_stb = st.stb;
    // count reference edges that see the reset low
    if (st.rst_s2)
      nx.rst_lo = '0;
    else if (!hold)
      nx.rst_lo = st.rst_lo + 2'h1;
    if (st.stb)
      nx.special = sc_app;
    for (int i = 0; i < NCH; i++)
    begin
      // error sticks; only reset or recentre clears it
      if (hold || recenter[i])
      begin
        nx.err[i] = 1'b0;
        nx.run[i] = 1'b0;
      end
      // overflow or underflow means drift past the centre
      if (!hold && !recenter[i] && st.run[i] &&
          ((fifo_wr[i] && !fifo_wready[i]) || (fifo_rd[i] && !fifo_rvalid[i])))
        nx.err[i] = 1'b1;
      // Reading starts once the buffer is half full.
      if (buf_en && !hold && !recenter[i] && !st.run[i] &&
          level[i] >= LW'(DEPTH / 2))
        nx.run[i] = 1'b1;
      if (hold)
        nx.ws[i] = '0;
      if (st.stb)
      begin
        nx.perr[i] = perr[i];
        nx.chr[i]  = word[i][qtipp_pkg::CODE_W-1:0];
        if (st.err[i] && !recenter[i])
        begin
          // continuous violation while the buffer is in error
          nx.src[i] = enc_en ? qtipp_pkg::SRC_VIOL : qtipp_pkg::SRC_RAW;
          if (!enc_en)
            nx.chr[i] = qtipp_pkg::C07_POS;
        end
        else if (recenter[i])
        begin
          // the recentring word sync still goes out
          nx.src[i] = qtipp_pkg::SRC_WSYNC;
          nx.ws[i]  = 4'(qtipp_pkg::WS_LEN - 1);
        end
        else if (st.ws[i] != '0)
        begin
          nx.src[i] = qtipp_pkg::SRC_WSYNC;
          nx.ws[i]  = st.ws[i] - 4'h1;
        end
        else if (!vld[i])
          nx.src[i] = enc_en ? qtipp_pkg::SRC_K285 : qtipp_pkg::SRC_RAW;
        else if (perr[i])
        begin
          nx.src[i] = enc_en ? qtipp_pkg::SRC_VIOL : qtipp_pkg::SRC_RAW;
          if (!enc_en)
            nx.chr[i] = qtipp_pkg::C07_POS;
        end
        else if (!enc_en)
          // bypass passes the ten bits untouched
          nx.src[i] = qtipp_pkg::SRC_RAW;
        else if (ws_req[i] || (sc_app && word[i][qtipp_pkg::WC_LSB] &&
                 st.m_s2[1:0] == qtipp_pkg::TRIT_MID))
        begin
          nx.src[i] = qtipp_pkg::SRC_WSYNC;
          nx.ws[i]  = 4'(qtipp_pkg::WS_LEN - 1);
        end
        else if (!word[i][qtipp_pkg::WC_LSB])
          nx.src[i] = qtipp_pkg::SRC_DATA;
        else if (sc_app && st.m_s2[1:0] == qtipp_pkg::TRIT_LOW)
          nx.src[i] = qtipp_pkg::SRC_SPECIAL;
        else
          nx.src[i] = qtipp_pkg::SRC_K285;
      end
      // buffer and parity errors share one flag
      nx.flag[i] = nx.err[i] || nx.perr[i];
    end
  end

  // State register; all outputs are taken from it.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= nx;
  end

  assign enc_strobe    = st.out_stb;
  assign enc_char      = st.chr;
  assign enc_source    = st.src;
  assign enc_special   = st.special;
  assign tx_error_flag = st.flag;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Two consecutive low samples of the synchronised reset.
  sequence two_low_s;
    !st.rst_s2 ##1 !st.rst_s2;
  endsequence

  hold_init_a: assert property (two_low_s |=> (st.err == '0 && st.run == '0))
    else $error("Buffers not initialised after two low reset edges.");

  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_chk
      sequence ws_start_s;
        st.stb && enc_en && vld[gi] && !perr[gi] && !st.err[gi] &&
        st.ws[gi] == '0 && ws_req[gi];
      endsequence

      err_sticky_a: assert property (
        st.err[gi] && !hold && !recenter[gi] |=> st.err[gi])
        else $error("Buffer error cleared without reset.");
      flag_err_a: assert property (st.err[gi] |-> st.flag[gi])
        else $error("Buffer error not shown on error flag.");
      viol_phase_a: assert property (
        st.stb && st.err[gi] && !recenter[gi] && enc_en
        |=> st.src[gi] == qtipp_pkg::SRC_VIOL)
        else $error("No violation character during buffer error.");
      par_sub_a: assert property (
        st.stb && !st.err[gi] && st.ws[gi] == '0 && perr[gi]
        |=> st.flag[gi] && (st.src[gi] == qtipp_pkg::SRC_VIOL ||
            (st.src[gi] == qtipp_pkg::SRC_RAW && st.chr[gi] == qtipp_pkg::C07_POS)))
        else $error("Parity error not substituted.");
      bypass_map_a: assert property (
        st.stb && !enc_en && vld[gi] && !perr[gi] && !st.err[gi]
        |=> st.chr[gi] == $past(word[gi][9:0]) && st.src[gi] == qtipp_pkg::SRC_RAW)
        else $error("Bypass character altered.");
      no_buf_a: assert property (
        st.stb && !buf_en && !perr[gi] && !st.err[gi]
        |=> st.chr[gi] == {$past(st.c_s2[2*gi +: 2]), $past(st.d_s2[8*gi +: 8])})
        else $error("Unbuffered character not taken straight from capture.");
      wsync_len_a: assert property (
        ws_start_s |=> st.src[gi] == qtipp_pkg::SRC_WSYNC && st.ws[gi] == 4'hF
        ##8 st.ws[gi] != '0)
        else $error("Word sync sequence too short.");
      par_off_a: assert property (
        st.pc_s2 == qtipp_pkg::TRIT_LOW |-> !perr[gi])
        else $error("Parity checked while disabled.");
    end
  endgenerate
endmodule : qtipp_tx_front
`default_nettype wire

// [qtipp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module qtipp_host_model (
  // Start and stop of the host clocks.
  input  wire logic        run,
  // Ask for the word sync control pair on every lane.
  input  wire logic        wsync,
  // Host character bus, one lane per channel.
  output logic [3:0]       clk_o,
  output logic [31:0]      d_o,
  output logic [7:0]       c_o,
  output logic [3:0]       p_o
);
  logic [7:0] cnt;

  // Clocks stand still low while stopped, so a stall really starves the buffers.
  // Data moves on the falling edge, half a character away from the sampling rise.
  initial
  begin
    clk_o = 4'h0;
    cnt   = 8'h00;
    c_o   = 8'h00;
    d_o   = 32'h0;
    p_o   = {4{~^cnt}};
    #13;
    forever
    begin
      if (run)
      begin
        #160 clk_o = 4'hF;
        #160 clk_o = 4'h0;
        cnt = cnt + 8'h01;
        d_o = {4{cnt}};
        c_o = {8{wsync}};
        p_o = {4{~^cnt}};
      end
      else
        #40;
    end
  end
endmodule : qtipp_host_model
`default_nettype wire

// [qtipp_tx_front_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module qtipp_tx_front_tb;
  typedef struct {
    logic [39:0] ch;
    logic [11:0] src;
    logic [3:0]  err;
    logic        sp;
    logic [1:0]  m;
  } qtipp_exp_t;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] d_b = '0, h_d, tx_d;
  logic [7:0]  c_b = '0, h_c, tx_c;
  logic [3:0]  p_b = '0, h_p, tx_p, h_clk, err_flag;
  logic [3:0]  mode = 4'h0;
  logic [1:0]  cks = 2'h0, pc = 2'h0;
  logic        sel = 1'b0, rate = 1'b0, brst = 1'b0, use_host = 1'b0, run = 1'b0;
  logic        stb, spc;
  logic        wsync = 1'b0;
  logic [39:0] ech;
  logic [11:0] esrc;
  logic [15:0] seed = 16'h64A2;
  logic [7:0]  prev;
  int          error_cnt = 0, checks = 0;
  qtipp_exp_t  q[$];
  qtipp_exp_t  mx;
  logic [5:0]  tbl[9] = '{6'h00, 6'h01, 6'h02, 6'h05, 6'h10, 6'h11, 6'h12, 6'h29, 6'h2A};

  always #20 mclk = ~mclk;

  // The host model owns the bus only in the buffered phase.
  assign tx_d = use_host ? h_d : d_b;
  assign tx_c = use_host ? h_c : c_b;
  assign tx_p = use_host ? h_p : p_b;

  qtipp_host_model qtipp_host_model_i (.run(run), .wsync(wsync), .clk_o(h_clk), .d_o(h_d),
    .c_o(h_c), .p_o(h_p));

  qtipp_tx_front qtipp_tx_front_i (.mclk(mclk), .resetn(resetn), .chan_input_clock(h_clk),
    .tx_char_bits(tx_d), .tx_ctrl_bits(tx_c), .tx_parity_bit(tx_p),
    .special_char_select(sel), .tx_mode_select(mode), .tx_clock_select(cks),
    .tx_rate_select(rate), .parity_control(pc), .tx_buffer_reset(brst),
    .enc_strobe(stb), .enc_char(ech), .enc_source(esrc), .enc_special(spc),
    .tx_error_flag(err_flag));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // An error is an even sum over the bits that the parity mode selects.
  function automatic logic perr(input logic [7:0] d, input logic [1:0] c, input logic p,
                                input logic [1:0] pcv, input logic enc);
    if (pcv == 2'h0)
      return 1'b0;
    if (pcv == 2'h1 && enc)
      return ~^{d, p};
    return ~^{d, c, p};
  endfunction : perr

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic wstb;
    int n;
    n = 0;
    @(negedge mclk);
    while (stb !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20)
    begin
      error_cnt++;
      conclude();
    end
  endtask : wstb

  // Drive one character on every lane a cycle after a strobe, and note what must follow.
  // Kind 0 is random, 1 starts a word sync, 2 fills the word sync slots.
  task automatic send(input int ws, input logic [3:0] md, input logic [1:0] pcv);
    qtipp_exp_t e;
    logic [7:0] d;
    logic [1:0] c;
    logic       p, er, enc;
    wstb();
    @(negedge mclk);
    mode = md;
    pc = pcv;
    enc = md[3:2] != qtipp_pkg::TRIT_LOW;
    seed = lfsr(seed);
    sel = seed[11] & (ws == 0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      d = seed[7:0];
      c = (ws == 1) ? 2'h3 : (ws == 2) ? 2'h0 : {seed[9] & ~seed[8], seed[8]};
      p = (ws != 0) ? ~^{d, c} : seed[10];
      er = perr(d, c, p, pcv, enc);
      d_b[8*i+:8] = d;
      c_b[2*i+:2] = c;
      p_b[i] = p;
      e.ch[10*i+:10] = er ? 10'h278 : {c, d};
      e.err[i] = er;
      e.src[3*i+:3] = (ws != 0) ? qtipp_pkg::SRC_WSYNC : !enc ? qtipp_pkg::SRC_RAW :
        er ? qtipp_pkg::SRC_VIOL : !c[0] ? qtipp_pkg::SRC_DATA :
        (sel && md[1:0] == qtipp_pkg::TRIT_LOW) ? qtipp_pkg::SRC_SPECIAL : qtipp_pkg::SRC_K285;
    end
    e.sp = sel;
    e.m = {md[1:0] == qtipp_pkg::TRIT_LOW && enc && ws == 0, !enc};
    q.push_back(e);
  endtask : send

  // Each strobe answers the oldest noted character.
  always @(negedge mclk)
    if (stb === 1'b1 && q.size() > 0)
    begin
      mx = q.pop_front();
      chk("source", 40'(esrc), 40'(mx.src));
      chk("error", 40'(err_flag), 40'(mx.err));
      if (mx.m[0])
        chk("char", ech, mx.ch);
      if (mx.m[1])
        chk("special", 40'(spc), 40'(mx.sp));
    end

  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    brst = 1'b1;
    wstb();
    foreach (tbl[k])
      repeat (12) send(0, tbl[k][5:2], tbl[k][1:0]);
    send(1, 4'h4, 2'h2);
    repeat (15) send(2, 4'h4, 2'h2);
    repeat (3) send(0, 4'h4, 2'h2);
    wstb();
    // Let the watcher take its last note off the queue before counting.
    @(negedge mclk);
    chk("pending", 40'(q.size()), 40'h0);
    use_host = 1'b1;
    cks = qtipp_pkg::TRIT_MID;
    rate = 1'b1;
    mode = 4'h0;
    run = 1'b1;
    brst = 1'b0;
    repeat (3) @(negedge mclk);
    brst = 1'b1;
    repeat (40) wstb();
    prev = ech[7:0];
    repeat (10)
    begin
      wstb();
      chk("order", 40'(ech[7:0]), 40'(8'(prev + 8'h01)));
      chk("drift", 40'(err_flag), 40'h0);
      prev = ech[7:0];
    end
    run = 1'b0;
    repeat (30) wstb();
    chk("starve", 40'(err_flag), 40'hF);
    chk("viol", 40'(ech[9:0]), 40'(qtipp_pkg::C07_POS));
    chk("viol src", 40'(esrc[2:0]), 40'(qtipp_pkg::SRC_RAW));
    run = 1'b1;
    repeat (20) wstb();
    chk("sticky", 40'(err_flag), 40'hF);
    brst = 1'b0;
    repeat (3) @(negedge mclk);
    brst = 1'b1;
    repeat (40) wstb();
    chk("cleared", 40'(err_flag), 40'h0);
    // atomic word sync recentres a failed buffer
    mode = 4'h4;
    run = 1'b0;
    repeat (30) wstb();
    chk("enc viol", 40'(esrc[2:0]), 40'(qtipp_pkg::SRC_VIOL));
    wsync = 1'b1;
    run = 1'b1;
    repeat (40) wstb();
    chk("recentred", 40'(err_flag), 40'h0);
    chk("resync", 40'(esrc[2:0]), 40'(qtipp_pkg::SRC_WSYNC));
    conclude();
  end
endmodule : qtipp_tx_front_tb
`default_nettype wire
